// [rtl/crx_consts.vh]
// Constants for the processor reset and side-bus glue block.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef CRX_CONSTS_VH
`define CRX_CONSTS_VH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CRX_CLK_PERIOD_NS      10
`define CRX_PROCESSOR_HARD_RESET_OUT_TIME_NS     1000000
`define CRX_PROCESSOR_HARD_RESET_OUT_CYCLES      (`CRX_PROCESSOR_HARD_RESET_OUT_TIME_NS / `CRX_CLK_PERIOD_NS)
`define CRX_INIT_CYCLES        4

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CRX_P92_HOT_RESET_BIT  0
`define CRX_P92_PROTECT_BIT    2
`define CRX_CFG4E_KBD_RST_BIT  1
`define CRX_CFG4E_COPROCESSOR_ERROR_IN_EN_BIT  4
`define CRX_CLKDIV_RSTDRV_BIT  3

// ------------------------------------------------------------
// Side-bus codes in mode B
// ------------------------------------------------------------
`define CRX_XCODE_IDLE         2'h0
`define CRX_XCODE_CLK_ADDR     2'h1
`define CRX_XCODE_CLK_DATA     2'h2
`define CRX_XCODE_ROM_KBD      2'h3

// ------------------------------------------------------------
// Address ranges
// ------------------------------------------------------------
`define CRX_UPPER_IO_BASE      16'h0800
`define CRX_UPPER_IO_LAST      16'h08ff

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CRX_MODE_RST           1'h0

`endif

// [rtl/crx_pulse_timer.v]
// Retriggerable pulse stretcher: output high for CYCLES clocks after a trigger.
// Assumes a single clock domain and synchronous trigger.
`timescale 1ns/1ns
module crx_pulse_timer #(
    parameter integer CYCLES = 4,
    parameter integer WIDTH  = 20
) (
    input  wire             ref_clk_in,
    input  wire             rst_n_in,
    input  wire             trig_in,
    output reg              pulse_out
);
    reg [WIDTH-1:0] count_r;
    reg [WIDTH-1:0] count_nxt;

    always @* begin
        count_nxt = count_r;
        if (trig_in) begin
            count_nxt = CYCLES[WIDTH-1:0];
        end else if (count_r != {WIDTH{1'b0}}) begin
            count_nxt = count_r - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r   <= {WIDTH{1'b0}};
            pulse_out <= 1'b0;
        end else begin
            count_r   <= count_nxt;
            pulse_out <= (count_nxt != {WIDTH{1'b0}});
        end
    end
endmodule

// [rtl/crx_glue.v]
// Processor reset and side-bus glue: side-bus selects, buffer control,
// processor interrupt and reset outputs for two strapped processor modes.
// Assumes all inputs synchronous to ref_clk_in; decode hits come from the
// bus controller as levels; the other parties keep their own protocol.
//
// Function
// - Read strobe low: buffer moves side data to system
// - Mode A: sample protect strap, show port bit 2
// - Buffer enable active for any side-bus decode
// - Mode A: low select is boot memory select
// - Mode A: high select for I/O 800h-8FFh
// - Mode B: selects form two-bit code, low first
// - Code 00 idle,01 clk addr,10 clk data,11 rom/kbd
// - Drive processor interrupt and separate non-maskable interrupt
// - Mode B: initialize asserted four clocks per event
// - Initialize from hot reset, shutdown, keyboard reset bit
// - Numeric error pin is IRQ13 unless bit 4 set
// - Mode A: hard reset one millisecond after events
// - Mode A: power good generates the other system resets
// - Mode A: expansion reset one millisecond after events
`timescale 1ns/1ns
`include "crx_consts.vh"
module crx_glue #(
    parameter integer PROCESSOR_HARD_RESET_OUT_CYCLES = `CRX_PROCESSOR_HARD_RESET_OUT_CYCLES,
    parameter integer TWIDTH        = 20
) (
    input  wire        ref_clk_in,
    input  wire        rst_n_in,
    input  wire        mode_strap_in,
    input  wire        power_good_in,
    input  wire        side_bus_read_strobe_n_in,
    input  wire        protect_strap_input_in,
    input  wire        io_cycle_in,
    input  wire        mem_cycle_in,
    input  wire [15:0] io_addr_in,
    input  wire        rom_decode_in,
    input  wire        kbd_decode_in,
    input  wire        clk_addr_decode_in,
    input  wire        clk_data_decode_in,
    input  wire [7:0]  sys_ctrl_port_in,
    input  wire [7:0]  cfg_4e_in,
    input  wire [7:0]  clk_div_in,
    input  wire        shutdown_cycle_in,
    input  wire        pic_int_in,
    input  wire        nmi_req_in,
    input  wire        coprocessor_error_n_in,
    output reg         mode_b_out,
    output reg         buffer_to_system_out,
    output reg         side_bus_buffer_enable_n_out,
    output reg         side_select_low_out,
    output reg         side_select_high_out,
    output reg         protect_status_out,
    output reg         cpu_int_out,
    output reg         cpu_nmi_out,
    output reg         cpu_init_out,
    output reg         processor_hard_reset_n_out,
    output reg         ignore_numeric_error_n_out,
    output reg         expansion_bus_reset_out,
    output reg         irq13_out,
    output reg         coprocessor_error_in_active_out
);
    // ------------------------------------------------------------
    // Mode strap capture
    // ------------------------------------------------------------
    reg       strap_done_r;
    reg       mode_b_r;
    reg       protect_r;
    reg       pg_r;
    reg [7:0] p92_r;
    reg [7:0] cfg_r;
    reg [7:0] div_r;

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strap_done_r <= 1'b0;
            mode_b_r     <= `CRX_MODE_RST;
            protect_r    <= 1'b0;
            pg_r         <= 1'b0;
            p92_r        <= 8'h00;
            cfg_r        <= 8'h00;
            div_r        <= 8'h00;
        end else begin
            strap_done_r <= 1'b1;
            if (!strap_done_r) begin
                mode_b_r  <= mode_strap_in;
                protect_r <= protect_strap_input_in;
            end
            pg_r  <= power_good_in;
            p92_r <= sys_ctrl_port_in;
            cfg_r <= cfg_4e_in;
            div_r <= clk_div_in;
        end
    end

    // ------------------------------------------------------------
    // Reset event detection
    // ------------------------------------------------------------
    wire pg_edge  = power_good_in & ~pg_r;
    wire hot_set  = sys_ctrl_port_in[`CRX_P92_HOT_RESET_BIT]
                    & ~p92_r[`CRX_P92_HOT_RESET_BIT];
    wire kbd_set  = cfg_4e_in[`CRX_CFG4E_KBD_RST_BIT] & ~cfg_r[`CRX_CFG4E_KBD_RST_BIT];
    wire drv_set  = clk_div_in[`CRX_CLKDIV_RSTDRV_BIT] & ~div_r[`CRX_CLKDIV_RSTDRV_BIT];
    wire init_evt = hot_set | shutdown_cycle_in | kbd_set;
    wire hrst_evt = pg_edge | init_evt;
    wire isa_evt  = pg_edge | hot_set | drv_set;

    wire init_pulse;
    wire hrst_pulse;
    wire isa_pulse;

    crx_pulse_timer #(.CYCLES(`CRX_INIT_CYCLES), .WIDTH(TWIDTH)) u_init (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .trig_in    (init_evt & mode_b_r),
        .pulse_out  (init_pulse)
    );
    crx_pulse_timer #(.CYCLES(PROCESSOR_HARD_RESET_OUT_CYCLES), .WIDTH(TWIDTH)) u_hrst (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .trig_in    (hrst_evt & ~mode_b_r),
        .pulse_out  (hrst_pulse)
    );
    crx_pulse_timer #(.CYCLES(PROCESSOR_HARD_RESET_OUT_CYCLES), .WIDTH(TWIDTH)) u_isa (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .trig_in    (isa_evt & ~mode_b_r),
        .pulse_out  (isa_pulse)
    );

    // ------------------------------------------------------------
    // Side-bus select decode
    // ------------------------------------------------------------
    reg  [1:0] code_nxt;
    wire       upper_io = io_cycle_in && (io_addr_in >= `CRX_UPPER_IO_BASE)
                          && (io_addr_in <= `CRX_UPPER_IO_LAST);
    wire       any_hit  = rom_decode_in | kbd_decode_in | clk_addr_decode_in
                          | clk_data_decode_in | upper_io;

    always @* begin
        code_nxt = `CRX_XCODE_IDLE;
        if (rom_decode_in | kbd_decode_in) begin
            code_nxt = `CRX_XCODE_ROM_KBD;
        end else if (clk_data_decode_in) begin
            code_nxt = `CRX_XCODE_CLK_DATA;
        end else if (clk_addr_decode_in) begin
            code_nxt = `CRX_XCODE_CLK_ADDR;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_b_out                   <= 1'b0;
            buffer_to_system_out         <= 1'b0;
            side_bus_buffer_enable_n_out <= 1'b1;
            side_select_low_out          <= 1'b0;
            side_select_high_out         <= 1'b0;
            protect_status_out           <= 1'b0;
            cpu_int_out                  <= 1'b0;
            cpu_nmi_out                  <= 1'b0;
            cpu_init_out                 <= 1'b0;
            processor_hard_reset_n_out   <= 1'b0;
            ignore_numeric_error_n_out   <= 1'b1;
            expansion_bus_reset_out      <= 1'b1;
            irq13_out                    <= 1'b0;
            coprocessor_error_in_active_out              <= 1'b0;
        end else begin
            mode_b_out           <= mode_b_r;
            buffer_to_system_out <= ~side_bus_read_strobe_n_in;
            side_bus_buffer_enable_n_out <= ~any_hit;
            if (mode_b_r) begin
                side_select_low_out  <= code_nxt[0];
                side_select_high_out <= code_nxt[1];
            end else begin
                side_select_low_out  <= rom_decode_in & mem_cycle_in;
                side_select_high_out <= upper_io;
            end
            protect_status_out <= ~mode_b_r & protect_r;
            cpu_int_out        <= pic_int_in;
            cpu_nmi_out        <= nmi_req_in;
            cpu_init_out       <= mode_b_r & init_pulse;
            processor_hard_reset_n_out <= mode_b_r | ~hrst_pulse;
            ignore_numeric_error_n_out <= 1'b1;
            expansion_bus_reset_out    <= ~mode_b_r & isa_pulse;
            if (cfg_4e_in[`CRX_CFG4E_COPROCESSOR_ERROR_IN_EN_BIT]) begin
                irq13_out       <= 1'b0;
                coprocessor_error_in_active_out <= ~coprocessor_error_n_in;
            end else begin
                irq13_out       <= ~coprocessor_error_n_in;
                coprocessor_error_in_active_out <= 1'b0;
            end
        end
    end
endmodule

// [tb/crx_glue_monitor.sv]
// Port checker for the glue block.
// Assumes binding onto crx_glue, one clock domain.
`timescale 1ns/1ns
module crx_glue_monitor (
    input wire        ref_clk_in,
    input wire        rst_n_in,
    input wire        side_bus_read_strobe_n_in,
    input wire        io_cycle_in,
    input wire [15:0] io_addr_in,
    input wire        rom_decode_in,
    input wire        kbd_decode_in,
    input wire        clk_addr_decode_in,
    input wire        clk_data_decode_in,
    input wire [7:0]  sys_ctrl_port_in,
    input wire        mode_b_out,
    input wire        buffer_to_system_out,
    input wire        side_bus_buffer_enable_n_out,
    input wire        side_select_high_out,
    input wire        side_select_low_out,
    input wire        cpu_init_out,
    input wire        processor_hard_reset_n_out,
    input wire        expansion_bus_reset_out
);
    reg  [1:0] up_r;
    wire       up  = up_r == 2'h3;
    wire       rng = io_cycle_in && io_addr_in[15:8] == 8'h08;
    wire       rk  = rom_decode_in | kbd_decode_in;
    wire       hit = rk | clk_addr_decode_in | clk_data_decode_in | rng;
    wire [1:0] cd  = rk ? 2'h3 : clk_data_decode_in ? 2'h2 : {1'b0, clk_addr_decode_in};
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            up_r <= 2'h0;
        else if (!up)
            up_r <= up_r + 2'h1;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    buf_dir_a:
    assert property (up |=> buffer_to_system_out == $past(!side_bus_read_strobe_n_in))
    else $error("buffer direction wrong");
    buf_en_a:
    assert property (up |=> side_bus_buffer_enable_n_out == $past(!hit))
    else $error("buffer enable wrong");
    io_sel_a:
    assert property (up && !mode_b_out |=> side_select_high_out == $past(rng))
    else $error("upper range select wrong");
    code_b_a:
    assert property (up && mode_b_out |=> {side_select_high_out, side_select_low_out} == $past(cd))
    else $error("side code wrong");
    init_go_a:
    assert property (up && mode_b_out && $rose(sys_ctrl_port_in[0]) |-> ##[1:3] $rose(cpu_init_out))
    else $error("init not started");
    init_len_a:
    assert property ($rose(cpu_init_out) |-> cpu_init_out [*4] ##1 !cpu_init_out)
    else $error("init length wrong");
    no_init_a:
    assert property (up && !mode_b_out |-> !cpu_init_out)
    else $error("init in mode A");
    mode_rst_a:
    assert property (up && mode_b_out |-> processor_hard_reset_n_out && !expansion_bus_reset_out)
    else $error("reset in mode B");
    mode_hold_a:
    assert property (up |=> $stable(mode_b_out))
    else $error("mode changed");
    cover property (up && mode_b_out && cd == 2'h3);
    cover property ($rose(cpu_init_out));
    cover property (up && $fell(processor_hard_reset_n_out));
endmodule
bind crx_glue crx_glue_monitor mon (.*);

// [tb/crx_side_decoder.sv]
// Far-side decoder turning the mode B code into device selects.
// Assumes the selects come straight from the glue block.
`timescale 1ns/1ns
module crx_side_decoder (
    input  wire side_select_low_in,
    input  wire side_select_high_in,
    output wire [2:0] cs_out
);
    assign cs_out[0] = !side_select_high_in && side_select_low_in;
    assign cs_out[1] = side_select_high_in && !side_select_low_in;
    assign cs_out[2] = side_select_high_in && side_select_low_in;
endmodule

// [tb/crx_glue_tb_top.sv]
// Self-checking bench for the glue block in both strapped modes.
// Assumes the side decoder model sits on the select lines.
`timescale 1ns/1ns
module crx_glue_tb_top;
    localparam integer H = 20;
    reg         ref_clk_in = 1'b0;
    reg         rst_n_in = 1'b0;
    reg         strap = 1'b0;
    reg         pgood = 1'b0;
    reg         strobe_n = 1'b1;
    reg         prot = 1'b1;
    reg         io = 1'b0;
    reg  [15:0] addr = 16'h0000;
    reg  [3:0]  dec = 4'h0;
    reg  [7:0]  p92 = 8'h00;
    reg  [7:0]  c4e = 8'h00;
    reg  [7:0]  cdiv = 8'h00;
    reg         shut = 1'b0;
    reg  [1:0]  irq = 2'h0;
    reg         err_n = 1'b1;
    reg         rng;
    reg  [1:0]  cd;
    wire [13:0] q;
    wire [2:0]  cs;
    integer     fails = 0, cmp_count = 0, cyc = 0, w0, w1, w2, m, e, d;
    always #5 ref_clk_in = !ref_clk_in;
    crx_glue #(.PROCESSOR_HARD_RESET_OUT_CYCLES(H)) DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .mode_strap_in(strap), .power_good_in(pgood), .side_bus_read_strobe_n_in(strobe_n),
        .protect_strap_input_in(prot), .io_cycle_in(io), .mem_cycle_in(!io), .io_addr_in(addr),
        .rom_decode_in(dec[3]), .kbd_decode_in(dec[2]), .clk_addr_decode_in(dec[1]),
        .clk_data_decode_in(dec[0]), .sys_ctrl_port_in(p92), .cfg_4e_in(c4e), .clk_div_in(cdiv),
        .shutdown_cycle_in(shut), .pic_int_in(irq[0]), .nmi_req_in(irq[1]),
        .coprocessor_error_n_in(err_n), .mode_b_out(q[13]), .buffer_to_system_out(q[12]),
        .side_bus_buffer_enable_n_out(q[11]), .side_select_low_out(q[10]),
        .side_select_high_out(q[9]), .protect_status_out(q[8]), .cpu_int_out(q[7]),
        .cpu_nmi_out(q[6]), .cpu_init_out(q[5]), .processor_hard_reset_n_out(q[4]),
        .ignore_numeric_error_n_out(q[3]), .expansion_bus_reset_out(q[2]), .irq13_out(q[1]),
        .coprocessor_error_in_active_out(q[0]));
    crx_side_decoder PART (.side_select_low_in(q[10]), .side_select_high_in(q[9]), .cs_out(cs));
    task tally_and_finish;
        begin
            $display("compares %0d mismatches %0d", cmp_count, fails);
            if (fails == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk_bit(input logic [2:0] g, input logic [2:0] x);
        begin
            cmp_count = cmp_count + 1;
            if (g !== x) begin
                fails = fails + 1;
                $display("[FAIL] %0t bit got %b exp %b", $time, g, x);
            end
        end
    endtask
    task chk_cnt(input integer g, input integer x);
        begin
            cmp_count = cmp_count + 1;
            if (g !== x) begin
                fails = fails + 1;
                $display("[FAIL] %0t width got %0d exp %0d", $time, g, x);
            end
        end
    endtask
    task fire(input integer ev);
        begin
            w0 = 0;
            w1 = 0;
            w2 = 0;
            p92[0] = ev == 0;
            shut = ev == 1;
            c4e[1] = ev == 2;
            cdiv[3] = ev == 3;
            pgood = pgood | (ev == 4);
            @(negedge ref_clk_in);
            p92[0] = 1'b0;
            shut = 1'b0;
            c4e[1] = 1'b0;
            cdiv[3] = 1'b0;
            repeat (40) begin
                w0 = w0 + q[5];
                w1 = w1 + !q[4];
                w2 = w2 + q[2];
                @(negedge ref_clk_in);
            end
        end
    endtask
    always @(posedge ref_clk_in) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            fails = fails + 1;
            tally_and_finish;
        end
    end
    initial begin
        for (m = 0; m < 2; m = m + 1) begin
            rst_n_in = 1'b0;
            strap = m[0];
            prot = 1'b1;
            pgood = 1'b0;
            repeat (4) @(negedge ref_clk_in);
            rst_n_in = 1'b1;
            @(negedge ref_clk_in);
            strap = !m[0];
            prot = 1'b0;
            repeat (30) @(negedge ref_clk_in);
            chk_bit(q[13], m[0]);
            chk_bit(q[8], !m[0]);
            for (d = 0; d < 16; d = d + 1) begin
                dec = d[3:0];
                io = d[0];
                addr = (d[2] ? 16'h0900 : 16'h0800) - {15'h0, d[1]};
                strobe_n = d[1];
                irq = d[3:2];
                err_n = d[0];
                c4e[4] = d[1];
                rng = io && addr[15:8] == 8'h08;
                cd = |dec[3:2] ? 2'h3 : dec[0] ? 2'h2 : {1'b0, dec[1]};
                repeat (2) @(negedge ref_clk_in);
                chk_bit(q[12], !strobe_n);
                chk_bit(q[11], !(|dec || rng));
                chk_bit(q[10], m ? cd[0] : dec[3] && !io);
                chk_bit(q[9], m ? cd[1] : rng);
                chk_bit({1'b0, q[6], q[7]}, {1'b0, irq});
                chk_bit({1'b0, q[0], q[1]}, {1'b0, !err_n && c4e[4], !err_n && !c4e[4]});
                chk_bit(q[3], 1'b1);
                if (m)
                    chk_bit(cs, {cd == 3, cd == 2, cd == 1});
            end
            for (e = 0; e < 5; e = e + 1) begin
                fire(e);
                chk_cnt(w0, (m && e < 3) ? 4 : 0);
                chk_cnt(w1, (!m && e != 3) ? H : 0);
                chk_cnt(w2, (!m && e != 1 && e != 2) ? H : 0);
            end
            $display("test in mode %0d done", m);
        end
        tally_and_finish;
    end
endmodule
